/* hdl/cgr_cfg.svh */
// Purpose: constants for the camera gpio output router
// Assumes: 40 MHz core clock
// Notes:   offsets are word addresses on the plain register port
`ifndef CGR_CFG_SVH
`define CGR_CFG_SVH

`define CGR_CLK_HZ          40000000
`define CGR_TICK_US         1
`define CGR_TICK_CYC        ((`CGR_CLK_HZ / 1000000) * `CGR_TICK_US)

`define CGR_OFS_SRC1        4'h0
`define CGR_OFS_SRC2        4'h1
`define CGR_OFS_SRC3        4'h2
`define CGR_OFS_INV         4'h3
`define CGR_OFS_STROBE1     4'h4
`define CGR_OFS_STROBE2     4'h5
`define CGR_OFS_STROBE3     4'h6
`define CGR_OFS_USER        4'h7
`define CGR_OFS_PULSE_HIGH  4'h8
`define CGR_OFS_PULSE_PER   4'h9
`define CGR_OFS_LAMP        4'ha
`define CGR_OFS_INPUTS      4'hb
`define CGR_OFS_STATUS      4'hc

`define CGR_RST_SRC1        4'h0
`define CGR_RST_SRC23       4'h7
`define CGR_RST_INV         3'h7
`define CGR_RST_USER        3'h0
`define CGR_RST_STROBE      32'h00000000
`define CGR_RST_PULSE_HIGH  21'h0001f4
`define CGR_RST_PULSE_PER   21'h0003e8
`define CGR_RST_LAMP        3'h1

`define CGR_PULSE_HIGH_MIN  21'h000001
`define CGR_PULSE_PER_MIN   21'h00000a
`define CGR_PULSE_MAX       21'h1e8480

`endif

/* hdl/cgr_pkg.sv */
// Purpose: types for the camera gpio output router
// Assumes: nothing
// Notes:   constants live in cgr_cfg.svh
`default_nettype none

package cgr_pkg;

  typedef enum logic [3:0] {
    CGR_SRC_EXPOSURE  = 4'h0,
    CGR_SRC_STROBE    = 4'h1,
    CGR_SRC_LINE      = 4'h2,
    CGR_SRC_FRAME     = 4'h3,
    CGR_SRC_READOUT   = 4'h4,
    CGR_SRC_TRIGGER   = 4'h5,
    CGR_SRC_PULSE     = 4'h6,
    CGR_SRC_USER1     = 4'h7,
    CGR_SRC_USER2     = 4'h8,
    CGR_SRC_USER3     = 4'h9
  } cgr_src_t;

  typedef struct packed {
    logic       exposure_active;
    logic       line_valid;
    logic       frame_valid;
    logic       trigger_in;
    logic       trigger_mode;
    logic       sensor_video;
    logic [2:0] strobe;
  } cgr_timing_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } cgr_bus_t;

endpackage : cgr_pkg

`default_nettype wire

/* hdl/cgr_pulse_gen.sv */
// Purpose: microsecond-based pulse train generator
// Assumes: high time and period already clamped to legal values
// Notes:   a period change takes effect at the next microsecond tick
`default_nettype none
`include "cgr_cfg.svh"

module cgr_pulse_gen
  import cgr_pkg::*;
#(
  parameter int TICK_CYC = `CGR_TICK_CYC,
  parameter int TW       = 21
) (
  input  wire logic          core_clk_i,
  input  wire logic          srst_i,
  input  wire logic [TW-1:0] high_us_i,
  input  wire logic [TW-1:0] period_us_i,
  output logic               pulse_o
);

  if (TICK_CYC < 1) begin : g_bad_tick
    $error("cgr_pulse_gen: TICK_CYC below one");
  end

  localparam int PW = $clog2(TICK_CYC + 1);

  logic [PW-1:0] pre_reg;
  logic [TW-1:0] us_reg;
  logic          pulse_reg;
  wire           tick    = (pre_reg == PW'(TICK_CYC - 1));
  wire           wrap    = tick && (us_reg >= period_us_i - TW'(1));
  wire [TW-1:0]  us_next = wrap ? '0 : us_reg + TW'(1);

  // ---------------------------------------------------------------
  // microsecond tick and period counter
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pre_reg   <= '0;
      us_reg    <= '0;
      pulse_reg <= 1'b0;
    end else begin
      pre_reg   <= tick ? '0 : pre_reg + PW'(1);
      if (tick) us_reg <= us_next;
      pulse_reg <= (tick ? us_next : us_reg) < high_us_i;
    end
  end

  assign pulse_o = pulse_reg;

endmodule : cgr_pulse_gen

`default_nettype wire

/* hdl/cgr_readout_det.sv */
// Purpose: sensor readout indication
// Assumes: sensor_video rises before optical black rows start
// Notes:   only meaningful in trigger mode
`default_nettype none

module cgr_readout_det
  import cgr_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic srst_i,
  input  wire logic trigger_mode_i,
  input  wire logic exposure_active_i,
  input  wire logic sensor_video_i,
  output logic      readout_o
);

  logic exp_d_reg;
  logic armed_reg;
  logic readout_reg;
  wire  exp_fall = exp_d_reg && !exposure_active_i;

  // ---------------------------------------------------------------
  // arm at end of exposure, assert while the sensor streams
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (srst_i || !trigger_mode_i) begin
      exp_d_reg   <= 1'b0;
      armed_reg   <= 1'b0;
      readout_reg <= 1'b0;
    end else begin
      exp_d_reg   <= exposure_active_i;
      armed_reg   <= exp_fall | (armed_reg & !readout_reg);
      // raised as the video sequence opens, ahead of black rows
      readout_reg <= (armed_reg | exp_fall | readout_reg) & sensor_video_i;
    end
  end

  assign readout_o = readout_reg;

endmodule : cgr_readout_det

`default_nettype wire

/* hdl/cgr_router.sv */
// Purpose: routes camera timing signals to three general outputs
// Assumes: all inputs synchronous to core_clk_i
// Notes:   lamp mode persistence is handed to an outside store
//
// Behaviour
// - three outputs picking from ten sources by code 0 to 9; output one refuses code 4.
// - per-output polarity after selection; 1 inverts and is the reset value.
// - each output keeps its own strobe configuration word.
// - three inputs readable; open inputs read 1 due to pull-ups.
// - readout signal follows exposure end into video, trigger mode only.
// - readout rises before optical black and effective pixels are sent.
// - readout source allowed on outputs two and three only, not one.
// - pulse train selectable on any output, 0.5 Hz to 100 kHz.
// - pulse high 1 to 2000000 us, period 10 to 2000000 us.
// - lamp mode 0 off, 1 on (default), 2 to 4 follow outputs one to three, 5 off.
// - lamp mode offered to the outside store after each write of 0 to 5, reloaded by lamp_restore_i with mode 0 to 5 unless a lamp write lands that cycle.
// - outputs two and three default to user definition 1, constant high.
`default_nettype none
`include "cgr_cfg.svh"

module cgr_router
  import cgr_pkg::*;
#(
  parameter int TICK_CYC = `CGR_TICK_CYC,
  parameter int TW       = 21
) (
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  input  wire cgr_timing_t timing_i,
  input  wire logic [2:0]  input_pin_query_i,
  input  wire cgr_bus_t    bus_i,
  output logic [31:0]      rdata_o,
  input  wire logic        lamp_restore_i,
  input  wire logic [2:0]  lamp_restore_mode_i,
  output logic             lamp_store_o,
  output logic [2:0]       lamp_store_mode_o,
  output logic             general_output_one_o,
  output logic             general_output_two_o,
  output logic             general_output_three_o,
  output logic             status_lamp_o,
  output logic             trigger_conflict_o
);

  // the clamp slices write data, so the counter width cannot pass the bus width
  if (TW < 21 || TW > 32) begin : g_bad_tw
    $error("cgr_router: TW must hold 2000000 us and fit a 32-bit word");
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [TW-1:0] clamp_us(input logic [31:0] v, input logic [TW-1:0] lo);
    logic [TW-1:0] r;
    r = v[TW-1:0];
    if (v < 32'(lo)) r = lo;
    else if (v > 32'(`CGR_PULSE_MAX)) r = TW'(`CGR_PULSE_MAX);
    return r;
  endfunction : clamp_us

  function automatic logic src_ok(input logic [31:0] v, input int idx);
    logic ok;
    ok = (v <= 32'h9);
    if (idx == 0 && v == 32'h4) ok = 1'b0;
    return ok;
  endfunction : src_ok

  // ---------------------------------------------------------------
  // configuration state
  // ---------------------------------------------------------------
  logic [3:0]    src_reg [3];
  logic [2:0]    inv_reg;
  logic [31:0]   strobe_reg [3];
  logic [2:0]    user_reg;
  logic [TW-1:0] pulse_high_reg;
  logic [TW-1:0] pulse_per_reg;
  logic [2:0]    lamp_reg;
  logic [31:0]   rdata_reg;
  logic [2:0]    gpo_reg;
  logic          lamp_out_reg;
  logic          lamp_store_reg;
  logic          conflict_reg;

  wire          pulse_w;
  wire          readout_w;
  wire [9:0]    src_vec [3];
  wire [2:0]    gpo_next;
  wire          wr_inv   = bus_i.wr && bus_i.addr == `CGR_OFS_INV;
  wire          wr_user  = bus_i.wr && bus_i.addr == `CGR_OFS_USER;
  wire          wr_high  = bus_i.wr && bus_i.addr == `CGR_OFS_PULSE_HIGH;
  wire          wr_per   = bus_i.wr && bus_i.addr == `CGR_OFS_PULSE_PER;
  wire          wr_lamp  = bus_i.wr && bus_i.addr == `CGR_OFS_LAMP && bus_i.wdata <= 32'h5;
  wire [TW-1:0] high_next = clamp_us(bus_i.wdata, `CGR_PULSE_HIGH_MIN);
  wire [TW-1:0] per_next  = clamp_us(bus_i.wdata, `CGR_PULSE_PER_MIN);

  // ---------------------------------------------------------------
  // sources shared by all outputs
  // ---------------------------------------------------------------
  cgr_pulse_gen #(
    .TICK_CYC (TICK_CYC),
    .TW       (TW)
  ) u_pulse (
    .core_clk_i  (core_clk_i),
    .srst_i      (srst_i),
    .high_us_i   (pulse_high_reg),
    .period_us_i (pulse_per_reg),
    .pulse_o     (pulse_w)
  );

  cgr_readout_det u_readout (
    .core_clk_i        (core_clk_i),
    .srst_i            (srst_i),
    .trigger_mode_i    (timing_i.trigger_mode),
    .exposure_active_i (timing_i.exposure_active),
    .sensor_video_i    (timing_i.sensor_video),
    .readout_o         (readout_w)
  );

  // ---------------------------------------------------------------
  // per-output selection and polarity
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_out
      localparam logic [3:0] OFS_SRC = `CGR_OFS_SRC1 + 4'(g);
      localparam logic [3:0] OFS_STB = `CGR_OFS_STROBE1 + 4'(g);
      wire wr_src = bus_i.wr && bus_i.addr == OFS_SRC && src_ok(bus_i.wdata, g);
      wire wr_stb = bus_i.wr && bus_i.addr == OFS_STB;

      assign src_vec[g] = {user_reg[2], user_reg[1], user_reg[0], pulse_w,
                           timing_i.trigger_in, readout_w, timing_i.frame_valid,
                           timing_i.line_valid, timing_i.strobe[g],
                           timing_i.exposure_active};
      // user definitions idle low so the inverter makes the default high
      assign gpo_next[g] = src_vec[g][src_reg[g]] ^ inv_reg[g];

      always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
          src_reg[g]    <= (g == 0) ? `CGR_RST_SRC1 : `CGR_RST_SRC23;
          strobe_reg[g] <= `CGR_RST_STROBE;
        end else begin
          if (wr_src) src_reg[g] <= bus_i.wdata[3:0];
          if (wr_stb) strobe_reg[g] <= bus_i.wdata;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // shared configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      inv_reg        <= `CGR_RST_INV;
      user_reg       <= `CGR_RST_USER;
      pulse_high_reg <= TW'(`CGR_RST_PULSE_HIGH);
      pulse_per_reg  <= TW'(`CGR_RST_PULSE_PER);
    end else begin
      if (wr_inv)  inv_reg        <= bus_i.wdata[2:0];
      if (wr_user) user_reg       <= bus_i.wdata[2:0];
      if (wr_high) pulse_high_reg <= high_next;
      if (wr_per)  pulse_per_reg  <= per_next;
    end
  end

  // ---------------------------------------------------------------
  // status lamp and its persistence
  // ---------------------------------------------------------------
  wire lamp_next = (lamp_reg == 3'h0) ? 1'b0 :
                   (lamp_reg == 3'h1) ? 1'b1 :
                   (lamp_reg == 3'h2) ? gpo_next[0] :
                   (lamp_reg == 3'h3) ? gpo_next[1] :
                   (lamp_reg == 3'h4) ? gpo_next[2] :
                   1'b0;                             // no fourth output here

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      lamp_reg       <= `CGR_RST_LAMP;
      lamp_store_reg <= 1'b0;
    end else begin
      lamp_store_reg <= wr_lamp;
      if (wr_lamp) lamp_reg <= bus_i.wdata[2:0];
      else if (lamp_restore_i && lamp_restore_mode_i <= 3'h5) lamp_reg <= lamp_restore_mode_i;
    end
  end

  // ---------------------------------------------------------------
  // outputs and read port
  // ---------------------------------------------------------------
  wire [31:0] rd_mux =
    (bus_i.addr == `CGR_OFS_SRC1)       ? {28'h0, src_reg[0]} :
    (bus_i.addr == `CGR_OFS_SRC2)       ? {28'h0, src_reg[1]} :
    (bus_i.addr == `CGR_OFS_SRC3)       ? {28'h0, src_reg[2]} :
    (bus_i.addr == `CGR_OFS_INV)        ? {29'h0, inv_reg} :
    (bus_i.addr == `CGR_OFS_STROBE1)    ? strobe_reg[0] :
    (bus_i.addr == `CGR_OFS_STROBE2)    ? strobe_reg[1] :
    (bus_i.addr == `CGR_OFS_STROBE3)    ? strobe_reg[2] :
    (bus_i.addr == `CGR_OFS_USER)       ? {29'h0, user_reg} :
    (bus_i.addr == `CGR_OFS_PULSE_HIGH) ? 32'(pulse_high_reg) :
    (bus_i.addr == `CGR_OFS_PULSE_PER)  ? 32'(pulse_per_reg) :
    (bus_i.addr == `CGR_OFS_LAMP)       ? {29'h0, lamp_reg} :
    (bus_i.addr == `CGR_OFS_INPUTS)     ? {29'h0, input_pin_query_i} :
    (bus_i.addr == `CGR_OFS_STATUS)     ? {28'h0, readout_w, gpo_reg} :
    32'h0;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rdata_reg    <= '0;
      gpo_reg      <= '0;
      lamp_out_reg <= 1'b0;
      conflict_reg <= 1'b0;
    end else begin
      rdata_reg    <= bus_i.rd ? rd_mux : 32'h0;
      gpo_reg      <= gpo_next;
      lamp_out_reg <= lamp_next;
      // flags trigger_in held high during readout; it is the far side's fault
      conflict_reg <= readout_w & timing_i.trigger_in;
    end
  end

  assign rdata_o                = rdata_reg;
  assign general_output_one_o   = gpo_reg[0];
  assign general_output_two_o   = gpo_reg[1];
  assign general_output_three_o = gpo_reg[2];
  assign status_lamp_o          = lamp_out_reg;
  assign lamp_store_o           = lamp_store_reg;
  assign lamp_store_mode_o      = lamp_reg;
  assign trigger_conflict_o     = conflict_reg;

endmodule : cgr_router

`default_nettype wire

/* verification/cgr_router_chk.sv */
// Purpose: port checks for the gpio output router
// Assumes: one clock, synchronous reset
// Notes:   sees only the router ports
`default_nettype none
module cgr_router_chk
  import cgr_pkg::*;
#(
  parameter int TICK_CYC = 40,
  parameter int TW       = 21
) (
  input wire logic        core_clk_i,
  input wire logic        srst_i,
  input wire cgr_timing_t timing_i,
  input wire logic [2:0]  input_pin_query_i,
  input wire cgr_bus_t    bus_i,
  input wire logic [31:0] rdata_o,
  input wire logic        lamp_restore_i,
  input wire logic [2:0]  lamp_restore_mode_i,
  input wire logic        lamp_store_o,
  input wire logic [2:0]  lamp_store_mode_o,
  input wire logic        general_output_one_o,
  input wire logic        general_output_two_o,
  input wire logic        general_output_three_o,
  input wire logic        status_lamp_o,
  input wire logic        trigger_conflict_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // helpers
  // ----
  wire       lamp_wr = bus_i.wr && bus_i.addr == 4'ha;
  wire [2:0] m       = lamp_store_mode_o;
  wire [2:0] g       = {general_output_three_o, general_output_two_o, general_output_one_o};
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  a_rdata_idle: assert property (!$past(bus_i.rd) |-> rdata_o == 32'h0) else $error("rdata not idle");
  a_pin_read: assert property (bus_i.rd && bus_i.addr == 4'hb |=> rdata_o == {29'h0, $past(input_pin_query_i)})
    else $error("pin read wrong");
  a_store_cause: assert property (lamp_wr && bus_i.wdata <= 32'h5 |=> lamp_store_o && m == $past(bus_i.wdata[2:0]))
    else $error("lamp store missing");
  a_store_only: assert property (lamp_store_o |-> $past(lamp_wr) && $past(bus_i.wdata) <= 32'h5)
    else $error("lamp store spurious");
  a_restore_load: assert property (lamp_restore_i && lamp_restore_mode_i <= 3'h5 |=> m == $past(lamp_restore_mode_i))
    else $error("lamp restore lost");
  a_lamp_fixed: assert property (!$past(srst_i) && $past(m) == m && m < 3'h2 |-> status_lamp_o == m[0])
    else $error("lamp fixed level wrong");
  a_lamp_five: assert property (!$past(srst_i) && $past(m) == m && m == 3'h5 |-> !status_lamp_o)
    else $error("lamp mode five lit");
  a_lamp_follow: assert property (!$past(srst_i) && $past(m) == m && m inside {[2:4]} |-> status_lamp_o == g[m - 3'h2])
    else $error("lamp not following");
  a_conflict_cause: assert property (trigger_conflict_o |-> $past(timing_i.trigger_in))
    else $error("conflict without trigger");
endmodule : cgr_router_chk

bind cgr_router cgr_router_chk #(.TICK_CYC(TICK_CYC), .TW(TW)) u_chk (.core_clk_i(core_clk_i), .srst_i(srst_i),
  .timing_i(timing_i), .input_pin_query_i(input_pin_query_i), .bus_i(bus_i), .rdata_o(rdata_o),
  .lamp_restore_i(lamp_restore_i), .lamp_restore_mode_i(lamp_restore_mode_i), .lamp_store_o(lamp_store_o),
  .lamp_store_mode_o(lamp_store_mode_o), .general_output_one_o(general_output_one_o),
  .general_output_two_o(general_output_two_o), .general_output_three_o(general_output_three_o),
  .status_lamp_o(status_lamp_o), .trigger_conflict_o(trigger_conflict_o));
`default_nettype wire

/* verification/cgr_ext_equip.sv */
// Purpose: outside equipment on the power connector
// Assumes: inputs pulled up when not driven
// Notes:   force_trig_i breaks the trigger hold-off on purpose
`default_nettype none
module cgr_ext_equip (
  input  wire logic       drive_en_i,
  input  wire logic [2:0] drive_val_i,
  input  wire logic       trig_req_i,
  input  wire logic       force_trig_i,
  input  wire logic       readout_seen_i,
  output logic [2:0]      pins_o,
  output logic            trig_o
);
  timeunit 1ns;
  timeprecision 1ps;
  assign pins_o = drive_en_i ? drive_val_i : 3'h7; // released pins float high
  assign trig_o = force_trig_i | (trig_req_i & ~readout_seen_i); // no requested trigger during readout; force_trig_i still passes
endmodule : cgr_ext_equip
`default_nettype wire

/* verification/camera_gpio_output_router_tb.sv */
// Purpose: self-checking bench for the gpio output router
// Assumes: microsecond tick shortened to 2 cycles
// Notes:   expectations come from the model state kept here
`default_nettype none
module camera_gpio_output_router_tb
  import cgr_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 2;
  logic        clk, srst, rst_l, lamp_st, g1, g2, g3, lamp, conf, d_en, trq, ftr, trig, ro_vis;
  logic [2:0]  d_val, pins, rst_m, lamp_m;
  logic [31:0] rdata;
  cgr_timing_t tb_t, tim;
  cgr_bus_t    bus;
  int          miscompares = 0, check_count = 0, seed = 64330;
  int          src[3], inv, usr, lmp, n, c, h, p;
  int          rv[16] = '{0, 7, 7, 7, -1, -1, -1, 0, 500, 1000, 1, -1, -1, 0, 0, 0};
  logic [31:0] sw[3];
  always_comb begin
    tim = tb_t;
    tim.trigger_in = trig;
  end
  // far side sees readout only where it is wired to output two; avoids a trigger loop
  always_comb ro_vis = (src[1] == 4) && (g2 ^ inv[1]);
  cgr_router #(.TICK_CYC(TK)) DUT (.core_clk_i(clk), .srst_i(srst), .timing_i(tim), .input_pin_query_i(pins),
    .bus_i(bus), .rdata_o(rdata), .lamp_restore_i(rst_l), .lamp_restore_mode_i(rst_m), .lamp_store_o(lamp_st),
    .lamp_store_mode_o(lamp_m), .general_output_one_o(g1), .general_output_two_o(g2),
    .general_output_three_o(g3), .status_lamp_o(lamp), .trigger_conflict_o(conf));
  cgr_ext_equip u_ext (.drive_en_i(d_en), .drive_val_i(d_val), .trig_req_i(trq), .force_trig_i(ftr),
    .readout_seen_i(ro_vis), .pins_o(pins), .trig_o(trig));
  // ----
  // model and bus tasks
  // ----
  function automatic logic [2:0] gexp(int r);
    logic [9:0] v;
    logic [2:0] g;
    for (int k = 0; k < 3; k++) begin
      v = {3'(usr), 1'b0, tim.trigger_in, r[0], tb_t.frame_valid, tb_t.line_valid, tb_t.strobe[k],
           tb_t.exposure_active};
      g[k] = v[src[k]] ^ inv[k];
    end
    return g;
  endfunction : gexp
  function automatic logic lexp();
    logic [2:0] g;
    g = gexp(0);
    if (lmp == 1) return 1'b1;
    if (lmp >= 2 && lmp <= 4) return g[lmp - 2];
    return 1'b0;
  endfunction : lexp
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(int a, int d);
    @(posedge clk);
    bus.addr <= 4'(a);
    bus.wdata <= 32'(d);
    bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(int a, int e);
    @(posedge clk);
    bus.addr <= 4'(a);
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    chk("rdata", 32'(e), rdata);
  endtask : rd
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask : settle
  task automatic pmeas();
    logic prv;
    h = 0;
    p = 0;
    prv = 1'b1;
    for (int k = 0; k < 5000 && !(g3 === 1'b1 && prv === 1'b0); k++) begin
      prv = g3;
      @(posedge clk);
      #1;
    end
    for (int k = 0; k < 5000; k++) begin
      if (g3 === 1'b1) h++;
      p++;
      prv = g3;
      @(posedge clk);
      #1;
      if (g3 === 1'b1 && prv === 1'b0) break;
    end
  endtask : pmeas
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    summarize();
  end
  // ----
  // scenarios
  // ----
  initial begin
    bus = '0;
    tb_t = '0;
    {rst_l, rst_m, d_en, d_val, trq, ftr} = '0;
    srst = 1'b1;
    src = '{0, 7, 7};
    inv = 7;
    usr = 0;
    lmp = 1;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    for (c = 0; c < 16; c++) if (rv[c] >= 0) rd(c, rv[c]);
    settle();
    chk("gpo", 32'(gexp(0)), {g3, g2, g1});
    for (n = 0; n < 3; n++) begin
      sw[n] = $random(seed);
      wr(4 + n, sw[n]);
    end
    for (n = 0; n < 3; n++) rd(4 + n, sw[n]);
    for (n = 0; n < 3; n++) for (c = 0; c < 12; c++) begin
      if (c == 6) continue;
      wr(n, c);
      if (c <= 9 && !(n == 0 && c == 4)) src[n] = c;
      rd(n, src[n]);
      inv = $random(seed) & 7;
      usr = $random(seed) & 7;
      wr(3, inv);
      wr(7, usr);
      @(posedge clk);
      tb_t <= 9'($random(seed)) & 9'h1ef;
      trq <= 1'($random(seed));
      settle();
      chk("gpo", 32'(gexp(0)), {g3, g2, g1});
    end
    wr(1, 4);
    src[1] = 4;
    wr(3, 0);
    inv = 0;
    @(posedge clk);
    tb_t <= 9'h008;
    trq <= 1'b0;
    settle();
    rd(12, {gexp(0)});
    @(posedge clk);
    tb_t <= 9'h110;
    settle();
    rd(12, {gexp(0)});
    @(posedge clk);
    tb_t <= 9'h018;
    settle();
    @(posedge clk);
    trq <= 1'b1;
    settle();
    rd(12, {1'b1, gexp(1)});
    chk("conflict", 0, conf);
    @(posedge clk);
    ftr <= 1'b1;
    settle();
    chk("conflict", 1, conf);
    @(posedge clk);
    ftr <= 1'b0;
    tb_t <= 9'h008;
    settle();
    rd(12, {gexp(0)});
    rd(11, 7);
    c = $random(seed) & 7;
    @(posedge clk);
    d_en <= 1'b1;
    d_val <= 3'(c);
    rd(11, c);
    for (c = 0; c < 7; c++) begin
      wr(10, c);
      if (c < 6) lmp = c;
      rd(10, lmp);
      settle();
      chk("lamp", 32'(lexp()), lamp);
    end
    @(posedge clk);
    rst_l <= 1'b1;
    rst_m <= 3'h3;
    @(posedge clk);
    rst_l <= 1'b0;
    rd(10, 3);
    wr(8, 0);
    rd(8, 1);
    wr(9, 3);
    rd(9, 10);
    wr(9, 2000001);
    rd(9, 2000000);
    wr(9, 10);
    wr(2, 6);
    wr(10, 4);
    pmeas();
    pmeas();
    chk("pulse high", TK, h);
    chk("pulse period", 10 * TK, p);
    summarize();
  end
endmodule : camera_gpio_output_router_tb
`default_nettype wire
